// File: logic/rio_pkg.sv
// What this block does
// - Up to twelve remote inputs, each assigned one selectable function code.
// - An active output-inhibit input forces all zone heater outputs off.
// - If any input is output-permit, heaters stay off unless one is active.
// - Function assignments change only while the change-permit setting is set.
// - With audible alarm fitted, output channel 1 drives the audible alarm.
// - Resettable mode: contact on after any zone alarm holds five seconds.
// - Resettable mode: acknowledge clears contact; later five-second alarm sets it again.
// - Non-resettable mode: contact on after five-second alarm; acknowledge ignored.
// - Non-resettable mode: contact off only when no alarm remains anywhere.
// - Run-permit is a normally-open contact closed when the mold is ready.
// - Run-permit open on interlink loss, unlocked zone off, blocking alarm, all locked.
// - Run-permit closes when one zone unlocked, all unlocked on, no blocking alarm.
// - Remote inputs act only after staying present for their input delay.
// - Remote outputs turn on only after the condition persists for the output delay.
// - Machine-ready input honoured only after its own separate delay.
// - Number of I/O pairs and each pair's module slot, one to four, configurable.
// - Remote standby: selected group uses standby setpoints, manual zones half output; here only STANDBY_REQ is raised.
// - Remote boost: selected group boosted for boost time, then returns automatically; here BOOST_REQ only follows the input, with no timer.
//
// Purpose: constants, register map and function codes for the remote I/O block
// Assumes: 20 MHz system clock
// Notes: registers are word indexed on a plain strobe port
package rio_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int ALARM_HOLD_S = 5;
  localparam int ADDR_W = 6;
  localparam int FUNC_W = 4;
  // Function codes for inputs
  typedef enum logic [3:0] {
    FI_NONE, FI_INHIBIT, FI_ALLOW, FI_STANDBY, FI_BOOST, FI_SEQ_START, FI_SEQ_COOL,
    FI_SEQ_POWERUP, FI_EVEN_COOL, FI_CYCLE_START, FI_WATER, FI_RESTORE, FI_READY
  } in_func_t;
  // Function codes for outputs
  typedef enum logic [3:0] {
    FO_NONE, FO_ALARM_RES, FO_ALARM_NONRES, FO_RUN_PERMIT, FO_AUDIBLE
  } out_func_t;
  // Register offsets
  localparam logic [5:0] REG_CTRL = 6'h00;      // [0] change permit, [1] audible fitted
  localparam logic [5:0] REG_ACK = 6'h01;       // Write 1 to bit 0 acknowledges alarm
  localparam logic [5:0] REG_STATUS = 6'h02;    // Derived status bits
  localparam logic [5:0] REG_IN_STATE = 6'h03;  // Qualified input levels
  localparam logic [5:0] REG_OUT_STATE = 6'h04; // Remote output levels
  localparam logic [5:0] REG_READY_DLY = 6'h05; // Machine-ready delay, seconds
  localparam logic [5:0] REG_PAIRS = 6'h06;     // Number of active pairs
  localparam logic [5:0] REG_IN_FUNC = 6'h10;   // 0x10..0x1b input functions
  localparam logic [5:0] REG_IN_DLY = 6'h1c;    // 0x1c..0x27 input delays
  localparam logic [5:0] REG_OUT_FUNC = 6'h28;  // 0x28..0x33 output functions
  localparam logic [5:0] REG_SLOT = 6'h34;      // 0x34..0x3f pair module slot
  localparam logic [7:0] DLY_RESET = 8'h00;
  localparam logic [1:0] SLOT_RESET = 2'h0;
  localparam int CTRL_PERMIT = 0;
  localparam int CTRL_AUDIBLE = 1;
endpackage

// File: logic/remote_io_alarm_interlock.sv
// Purpose: remote input qualification, function mapping, alarm and run-permit contacts
// Assumes: all inputs synchronous to CLK_SYS; output channel index also selects delay
// Notes: output delays share the input delay table per I/O pair
`timescale 1ns/1ps
module remote_io_alarm_interlock
  import rio_pkg::*;
#(
  parameter int NCH = 12,
  parameter int NZONE = 8,
  parameter int DLY_W = 8,
  parameter int TICK_CYC = CLK_HZ
) (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic [NCH-1:0] REMOTE_IN,
  input wire logic [NZONE-1:0] ZONE_ALARM,
  input wire logic [NZONE-1:0] ZONE_PERMIT_BLOCK,
  input wire logic [NZONE-1:0] ZONE_ON,
  input wire logic [NZONE-1:0] ZONE_LOCKED,
  input wire logic OTHER_ALARM,
  input wire logic INTERLINK_OK,
  output logic HEAT_ENABLE,
  output logic STANDBY_REQ,
  output logic BOOST_REQ,
  output logic WATER_FLOW,
  output logic MACHINE_READY,
  output logic [NCH-1:0] REMOTE_OUT,
  output logic [NCH-1:0] OUT_CHANNEL_EN
);
  // Elaboration checks: the pair count register is four bits wide and
  // delays are taken straight from the low bits of the write data
  if (NCH < 1 || NCH > 12) begin : g_bad_nch
    $error("NCH must be 1..12");
  end
  if (TICK_CYC < 1) begin : g_bad_tick
    $error("TICK_CYC must be positive");
  end
  if (DLY_W < 8 || DLY_W > 32) begin : g_bad_dly
    $error("DLY_W must be 8..32");
  end

  logic [31:0] tick_cnt;
  logic tick;
  logic change_permit, audible_fitted, ack;
  logic [3:0] pairs;
  logic [DLY_W-1:0] ready_dly;
  logic [FUNC_W-1:0] in_func [NCH];
  logic [FUNC_W-1:0] out_func [NCH];
  logic [DLY_W-1:0] io_dly [NCH];
  logic [1:0] slot [NCH];
  logic [DLY_W-1:0] in_cnt [NCH];
  logic [DLY_W-1:0] out_cnt [NCH];
  logic [NCH-1:0] in_q, cond, out_q;
  logic [DLY_W-1:0] rdy_cnt;
  logic rdy_q;
  logic [2:0] alm_cnt;
  logic any_alarm, alarm_latch;
  logic inhibit, allow_used, allow_act, run_permit;

  // One-second tick shared by every delay counter
  // A free-running divider keeps all delays on one grid, so a delay of N
  // seconds really lasts between N-1 and N seconds; cheaper than per-channel dividers
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      tick_cnt <= 32'h0;
      tick <= 1'b0;
    end else if (tick_cnt == 32'(TICK_CYC - 1)) begin
      tick_cnt <= 32'h0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
      tick <= 1'b0;
    end
  end

  // Control and configuration writes; assignments locked unless permit set
  // Delay and slot words stay writable while locked: only a function code
  // can switch heaters or contacts, so only those are guarded
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      change_permit <= 1'b0;
      audible_fitted <= 1'b0;
      ready_dly <= DLY_W'(DLY_RESET);
      pairs <= 4'(NCH);
      for (int i = 0; i < NCH; i++) begin
        in_func[i] <= FI_NONE;
        out_func[i] <= FO_NONE;
        io_dly[i] <= DLY_W'(DLY_RESET);
        slot[i] <= SLOT_RESET;
      end
    end else if (WR) begin
      if (ADDR == REG_CTRL) begin
        change_permit <= WDATA[CTRL_PERMIT];
        audible_fitted <= WDATA[CTRL_AUDIBLE];
      end
      if (ADDR == REG_READY_DLY) ready_dly <= WDATA[DLY_W-1:0];
      if (ADDR == REG_PAIRS && WDATA[3:0] <= 4'(NCH)) pairs <= WDATA[3:0];
      for (int i = 0; i < NCH; i++) begin
        if (change_permit && ADDR == REG_IN_FUNC + 6'(i)) in_func[i] <= WDATA[3:0];
        if (change_permit && ADDR == REG_OUT_FUNC + 6'(i)) out_func[i] <= WDATA[3:0];
        if (ADDR == REG_IN_DLY + 6'(i)) io_dly[i] <= WDATA[DLY_W-1:0];
        if (ADDR == REG_SLOT + 6'(i)) slot[i] <= WDATA[1:0];
      end
    end
  end

  // Acknowledge is a one-cycle pulse from a register write
  // Writing zero to the acknowledge word does nothing, so a stray write is harmless
  assign ack = WR && ADDR == REG_ACK && WDATA[0];

  // Input qualification: counter restarts whenever the input drops
  // Channels beyond the active pair count read as absent whatever their pin does
  // A zero delay still costs one clock to qualify, which filters nothing
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < NCH; i++) in_cnt[i] <= '0;
      in_q <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (!REMOTE_IN[i] || i >= pairs) begin
          in_cnt[i] <= '0;
          in_q[i] <= 1'b0;
        end else if (in_cnt[i] >= io_dly[i]) begin
          in_q[i] <= 1'b1;
        end else if (tick) begin
          in_cnt[i] <= in_cnt[i] + 1'b1;
        end
      end
    end
  end

  // Machine-ready uses its own delay on top of the input channel
  // The channel's input delay runs first, so the two delays add up
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      rdy_cnt <= '0;
      rdy_q <= 1'b0;
    end else begin
      logic raw;
      raw = 1'b0;
      for (int i = 0; i < NCH; i++) if (in_q[i] && in_func[i] == FI_READY) raw = 1'b1;
      if (!raw) begin
        rdy_cnt <= '0;
        rdy_q <= 1'b0;
      end else if (rdy_cnt >= ready_dly) begin
        rdy_q <= 1'b1;
      end else if (tick) begin
        rdy_cnt <= rdy_cnt + 1'b1;
      end
    end
  end

  // Function decode of qualified inputs
  // Allow only gates heat once some active channel carries that function;
  // otherwise an unconfigured controller could never heat
  always_comb begin
    inhibit = 1'b0;
    allow_used = 1'b0;
    allow_act = 1'b0;
    STANDBY_REQ = 1'b0;
    BOOST_REQ = 1'b0;
    WATER_FLOW = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if (in_q[i] && in_func[i] == FI_INHIBIT) inhibit = 1'b1;
      if (i < pairs && in_func[i] == FI_ALLOW) allow_used = 1'b1;
      if (in_q[i] && in_func[i] == FI_ALLOW) allow_act = 1'b1;
      if (in_q[i] && in_func[i] == FI_STANDBY) STANDBY_REQ = 1'b1;
      if (in_q[i] && in_func[i] == FI_BOOST) BOOST_REQ = 1'b1;
      if (in_q[i] && in_func[i] == FI_WATER) WATER_FLOW = 1'b1;
    end
  end

  assign HEAT_ENABLE = !inhibit && (!allow_used || allow_act);
  assign MACHINE_READY = rdy_q;

  // Five-second continuous alarm detector
  // The count saturates at the hold time, so a standing alarm keeps it there
  assign any_alarm = |ZONE_ALARM;
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      alm_cnt <= 3'h0;
    end else if (!any_alarm) begin
      alm_cnt <= 3'h0;
    end else if (tick && alm_cnt < 3'(ALARM_HOLD_S)) begin
      alm_cnt <= alm_cnt + 3'h1;
    end
  end

  // Resettable latch: set after hold time, cleared by acknowledge, set wins
  // Re-arming needs the alarm to drop, so a standing alarm stays silenced
  logic alm_armed;
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      alarm_latch <= 1'b0;
      alm_armed <= 1'b1;
    end else begin
      if (!any_alarm) alm_armed <= 1'b1;
      if (alm_cnt == 3'(ALARM_HOLD_S) && alm_armed) begin
        alarm_latch <= 1'b1;
        // One set per alarm run, else a standing alarm would beat every acknowledge
        alm_armed <= !any_alarm;
      end else if (ack) begin
        alarm_latch <= 1'b0;
      end
    end
  end

  // Non-resettable contact: on after hold, off only when nothing is alarming
  // Other alarms keep it on but never start it; only zone alarms count the hold
  logic nonres;
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) nonres <= 1'b0;
    else if (alm_cnt == 3'(ALARM_HOLD_S)) nonres <= 1'b1;
    else if (!any_alarm && !OTHER_ALARM) nonres <= 1'b0;
  end

  // Run-permit conditions
  // Open by default: any doubt about the mold leaves the machine waiting
  always_comb begin
    logic all_locked, unlocked_off;
    all_locked = &ZONE_LOCKED;
    unlocked_off = |(~ZONE_LOCKED & ~ZONE_ON);
    run_permit = INTERLINK_OK && !all_locked && !unlocked_off
      && !(|ZONE_PERMIT_BLOCK);
  end

  // Per-output conditions, channel 1 forced to audible alarm when fitted
  // Channels beyond the pair count are held off so an unused contact never closes
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      out_func_t f;
      f = out_func_t'(out_func[i]);
      if (i == 0 && audible_fitted) f = FO_AUDIBLE;
      case (f)
        FO_ALARM_RES: cond[i] = alarm_latch;
        FO_ALARM_NONRES: cond[i] = nonres;
        FO_RUN_PERMIT: cond[i] = run_permit;
        FO_AUDIBLE: cond[i] = alarm_latch;
        default: cond[i] = 1'b0;
      endcase
      if (i >= pairs) cond[i] = 1'b0;
    end
  end

  // Output delay: turn-on is delayed, turn-off is immediate
  // One delay word per pair serves both directions, keeping the table small
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < NCH; i++) out_cnt[i] <= '0;
      out_q <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (!cond[i]) begin
          out_cnt[i] <= '0;
          out_q[i] <= 1'b0;
        end else if (out_cnt[i] >= io_dly[i]) begin
          out_q[i] <= 1'b1;
        end else if (tick) begin
          out_cnt[i] <= out_cnt[i] + 1'b1;
        end
      end
    end
  end

  assign REMOTE_OUT = out_q;
  always_comb begin
    for (int i = 0; i < NCH; i++) OUT_CHANNEL_EN[i] = (i < pairs);
  end

  // Register read, data one cycle after strobe; unmapped reads zero
  // Data hold until the next read, though the master only takes them the cycle after
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      RDATA <= 32'h0;
    end else if (RD) begin
      RDATA <= 32'h0;
      case (ADDR)
        REG_CTRL: RDATA <= {30'h0, audible_fitted, change_permit};
        REG_STATUS: RDATA <= {26'h0, rdy_q, run_permit, nonres, alarm_latch, inhibit,
          HEAT_ENABLE};
        REG_IN_STATE: RDATA <= 32'(in_q);
        REG_OUT_STATE: RDATA <= 32'(out_q);
        REG_READY_DLY: RDATA <= 32'(ready_dly);
        REG_PAIRS: RDATA <= {28'h0, pairs};
        default: begin
          for (int i = 0; i < NCH; i++) begin
            if (ADDR == REG_IN_FUNC + 6'(i)) RDATA <= {28'h0, in_func[i]};
            if (ADDR == REG_IN_DLY + 6'(i)) RDATA <= 32'(io_dly[i]);
            if (ADDR == REG_OUT_FUNC + 6'(i)) RDATA <= {28'h0, out_func[i]};
            if (ADDR == REG_SLOT + 6'(i)) RDATA <= {30'h0, slot[i]};
          end
        end
      endcase
    end
  end
endmodule

// File: testbench/rio_props.sv
// Purpose: port assertions for the remote I/O block
// Assumes: bench puts contact and input functions under test on channel 0
// Notes: settings are shadowed from the write port, so reads are not needed
`timescale 1ns/1ps
module rio_props
  import rio_pkg::*;
#(
  parameter int NCH = 12,
  parameter int NZONE = 8,
  parameter int TICK_CYC = 10
) (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic [NCH-1:0] REMOTE_IN,
  input wire logic [NZONE-1:0] ZONE_ALARM,
  input wire logic [NZONE-1:0] ZONE_PERMIT_BLOCK,
  input wire logic [NZONE-1:0] ZONE_ON,
  input wire logic [NZONE-1:0] ZONE_LOCKED,
  input wire logic OTHER_ALARM,
  input wire logic INTERLINK_OK,
  input wire logic HEAT_ENABLE,
  input wire logic STANDBY_REQ,
  input wire logic [NCH-1:0] REMOTE_OUT
);
  logic permit;
  logic [3:0] if0, of0;
  logic [7:0] dly0;
  int alm_run, in_run;
  wire logic any_alm = (|ZONE_ALARM) | OTHER_ALARM;
  wire logic ack = WR && ADDR == REG_ACK && WDATA[0];
  // Ready condition; each term is broken by one bench row
  wire logic ok = INTERLINK_OK && (|(~ZONE_LOCKED)) && (&(ZONE_ON | ZONE_LOCKED))
    && !(|ZONE_PERMIT_BLOCK);
  // Shadow settings; function codes move only while changes are allowed
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      permit <= 1'b0;
      if0 <= 4'h0;
      of0 <= 4'h0;
      dly0 <= DLY_RESET;
    end else if (WR) begin
      if (ADDR == REG_CTRL) permit <= WDATA[CTRL_PERMIT];
      if (ADDR == REG_IN_FUNC && permit) if0 <= WDATA[3:0];
      if (ADDR == REG_OUT_FUNC && permit) of0 <= WDATA[3:0];
      if (ADDR == REG_IN_DLY) dly0 <= WDATA[7:0];
    end
  end
  // Current run lengths in cycles; a drop restarts them
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      alm_run <= 0;
      in_run <= 0;
    end else begin
      alm_run <= (|ZONE_ALARM) ? alm_run + 1 : 0;
      in_run <= REMOTE_IN[0] ? in_run + 1 : 0;
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  AST_ALARM_HOLD: assert property (of0 inside {4'h1, 4'h2} && $rose(REMOTE_OUT[0])
    |-> $past(alm_run, 3) + 3 >= 4 * TICK_CYC) else $error("alarm contact early");
  AST_NONRES_HOLD: assert property (any_alm[*3] ##0 (of0 == 4'h2 && REMOTE_OUT[0])
    |=> REMOTE_OUT[0]) else $error("nonres contact dropped");
  AST_NONRES_CLEAR: assert property ((!any_alm && of0 == 4'h2)[*2]
    |-> ##[0:3] !REMOTE_OUT[0]) else $error("nonres contact stuck");
  AST_RES_ACK: assert property (ack && of0 == 4'h1 |-> ##[1:3] !REMOTE_OUT[0])
    else $error("ack ignored");
  AST_PERMIT_OPEN: assert property (of0 == 4'h3 && REMOTE_OUT[0] |-> $past(ok))
    else $error("permit closed while not ready");
  AST_PERMIT_CLOSE: assert property ((of0 == 4'h3 && dly0 == 8'h00 && ok)[*6]
    |-> REMOTE_OUT[0]) else $error("permit not closed");
  AST_INHIBIT: assert property ((if0 == 4'h1 && dly0 == 8'h00 && REMOTE_IN[0])[*6]
    |-> !HEAT_ENABLE) else $error("heat not inhibited");
  AST_IN_DELAY: assert property (if0 == 4'h3 && $rose(STANDBY_REQ)
    |-> in_run + 2 * TICK_CYC >= dly0 * TICK_CYC) else $error("input acted early");
  COV_NONRES: cover property (of0 == 4'h2 && REMOTE_OUT[0]);
  COV_ACK: cover property (ack && of0 == 4'h1 && REMOTE_OUT[0]);
  COV_PERMIT: cover property (of0 == 4'h3 && $rose(REMOTE_OUT[0]));
endmodule
bind remote_io_alarm_interlock rio_props #(.NCH(NCH), .NZONE(NZONE), .TICK_CYC(TICK_CYC))
  rio_props_inst (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .REMOTE_IN(REMOTE_IN), .ZONE_ALARM(ZONE_ALARM), .ZONE_PERMIT_BLOCK(ZONE_PERMIT_BLOCK),
  .ZONE_ON(ZONE_ON), .ZONE_LOCKED(ZONE_LOCKED), .OTHER_ALARM(OTHER_ALARM),
  .INTERLINK_OK(INTERLINK_OK), .HEAT_ENABLE(HEAT_ENABLE), .STANDBY_REQ(STANDBY_REQ),
  .REMOTE_OUT(REMOTE_OUT));

// File: testbench/machine_model.sv
// Purpose: molding machine end of the remote cable
// Assumes: one clock shared with the block
// Notes: ready lags the request to model a slow machine
`timescale 1ns/1ps
module machine_model #(
  parameter int LAG = 3
) (
  input wire logic clk,
  input wire logic plugged,
  input wire logic want_ready,
  input wire logic cooling,
  output logic interlink_ok,
  output logic ready_line,
  output logic water_on
);
  logic [7:0] hist;
  // Ready follows the machine's own state after its lag
  always @(posedge clk) begin
    hist <= {hist[6:0], want_ready};
  end
  assign ready_line = (hist[LAG-1] === 1'b1);
  assign water_on = cooling;
  assign interlink_ok = plugged;
endmodule

// File: testbench/remote_io_alarm_interlock_test.sv
// Purpose: self-checking bench for the remote I/O block
// Assumes: one tick shortened to 10 cycles
// Notes: channel 0 holds the function under test; machine drives inputs 2 and 3
`timescale 1ns/1ps
module remote_io_alarm_interlock_test
  import rio_pkg::*;
;
  typedef struct packed {logic plug; logic [7:0] on, lock, blk; logic permit;} row_t;
  // Permit cases: all good, then one broken condition per row, except row 3 where one locked zone left off still closes it
  row_t rows [6] = '{'{1'b1, 8'hff, 8'h00, 8'h00, 1'b1}, '{1'b0, 8'hff, 8'h00, 8'h00, 1'b0},
    '{1'b1, 8'hfe, 8'h00, 8'h00, 1'b0}, '{1'b1, 8'hfe, 8'h01, 8'h00, 1'b1},
    '{1'b1, 8'h00, 8'hff, 8'h00, 1'b0}, '{1'b1, 8'hff, 8'h00, 8'h10, 1'b0}};
  logic clk, rst_b, wr_s, rd_s, other, plug, want, cool, link_ok, ready_line, water_on;
  logic heat, stby, boost, water, mready;
  logic [5:0] addr;
  logic [31:0] wdata, rdata;
  logic [11:0] rin, rout, ch_en;
  logic [7:0] alarm, blk, zon, zlock;
  int n_fail = 0;
  int n_tests = 0;
  remote_io_alarm_interlock #(.TICK_CYC(10)) remote_io_alarm_interlock_inst (
    .CLK_SYS(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .REMOTE_IN({rin[11:4], water_on, ready_line, rin[1:0]}),
    .ZONE_ALARM(alarm), .ZONE_PERMIT_BLOCK(blk), .ZONE_ON(zon), .ZONE_LOCKED(zlock),
    .OTHER_ALARM(other), .INTERLINK_OK(link_ok), .HEAT_ENABLE(heat), .STANDBY_REQ(stby),
    .BOOST_REQ(boost), .WATER_FLOW(water), .MACHINE_READY(mready), .REMOTE_OUT(rout),
    .OUT_CHANNEL_EN(ch_en));
  machine_model machine_model_inst (.clk(clk), .plugged(plug), .want_ready(want), .cooling(cool),
    .interlink_ok(link_ok), .ready_line(ready_line), .water_on(water_on));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Waits end on a falling edge so outputs have settled
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (e !== g) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk("rdata", e, rdata);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    {rst_b, wr_s, rd_s, other, want} = 5'h0;
    {addr, wdata, rin, alarm, blk, zlock} = '0;
    {zon, plug} = 9'h1ff;
    cool = 1'b1;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    wr(REG_CTRL, 32'h1);
    wr(REG_OUT_FUNC, 32'(FO_RUN_PERMIT));
    wr(REG_IN_FUNC + 6'h2, 32'(FI_READY));
    wr(REG_IN_FUNC + 6'h3, 32'(FI_WATER));
    wr(REG_READY_DLY, 32'h2);
    foreach (rows[i]) begin
      @(posedge clk) {plug, zon, zlock, blk} <= rows[i][25:1];
      w(8);
      chk("run_permit", 32'(rows[i].permit), 32'(rout[0]));
    end
    $display("test permit table done");
    @(posedge clk) want <= 1'b1;
    w(8);
    chk("ready_early", 32'h0, 32'(mready));
    w(40);
    chk("ready", 32'h1, 32'(mready));
    chk("water", 32'h1, 32'(water));
    @(posedge clk) cool <= 1'b0;
    w(3);
    chk("water_off", 32'h0, 32'(water));
    wr(REG_CTRL, 32'h0);
    wr(REG_IN_FUNC, 32'(FI_INHIBIT));
    rd_chk(REG_IN_FUNC, 32'(FI_NONE));
    wr(REG_CTRL, 32'h1);
    wr(REG_IN_FUNC, 32'(FI_INHIBIT));
    rd_chk(REG_IN_FUNC, 32'(FI_INHIBIT));
    @(posedge clk) rin[0] <= 1'b1;
    w(6);
    chk("inhibit", 32'h0, 32'(heat));
    @(posedge clk) rin[0] <= 1'b0;
    wr(REG_IN_FUNC + 6'h1, 32'(FI_ALLOW));
    w(6);
    chk("allow_off", 32'h0, 32'(heat));
    @(posedge clk) rin[1] <= 1'b1;
    w(6);
    chk("allow_on", 32'h1, 32'(heat));
    // A short pulse must not count toward the next one
    wr(REG_IN_DLY, 32'h3);
    wr(REG_IN_FUNC, 32'(FI_STANDBY));
    @(posedge clk) rin[0] <= 1'b1;
    w(18);
    @(posedge clk) rin[0] <= 1'b0;
    @(posedge clk) rin[0] <= 1'b1;
    w(15);
    chk("standby_early", 32'h0, 32'(stby));
    w(30);
    chk("standby", 32'h1, 32'(stby));
    wr(REG_IN_FUNC, 32'(FI_BOOST));
    w(1);
    chk("boost", 32'h1, 32'(boost));
    chk("standby_off", 32'h0, 32'(stby));
    @(posedge clk) rin[0] <= 1'b0;
    wr(REG_IN_DLY, 32'h0);
    $display("test inputs done");
    wr(REG_OUT_FUNC, 32'(FO_ALARM_RES));
    @(posedge clk) alarm <= 8'h04;
    w(30);
    chk("alarm_early", 32'h0, 32'(rout[0]));
    w(40);
    chk("alarm", 32'h1, 32'(rout[0]));
    wr(REG_ACK, 32'h1);
    w(3);
    chk("alarm_ack", 32'h0, 32'(rout[0]));
    @(posedge clk) alarm <= 8'h00;
    @(posedge clk) alarm <= 8'h80;
    w(70);
    chk("alarm_again", 32'h1, 32'(rout[0]));
    wr(REG_OUT_FUNC, 32'(FO_ALARM_NONRES));
    wr(REG_ACK, 32'h1);
    w(3);
    chk("nonres_ack", 32'h1, 32'(rout[0]));
    @(posedge clk) {alarm, other} <= 9'h001;
    w(5);
    chk("nonres_other", 32'h1, 32'(rout[0]));
    @(posedge clk) other <= 1'b0;
    w(5);
    chk("nonres_clear", 32'h0, 32'(rout[0]));
    $display("test alarms done");
    wr(REG_OUT_FUNC, 32'(FO_NONE));
    wr(REG_ACK, 32'h1);
    wr(REG_CTRL, 32'h3);
    @(posedge clk) alarm <= 8'h02;
    w(70);
    chk("audible", 32'h1, 32'(rout[0]));
    @(posedge clk) alarm <= 8'h00;
    wr(REG_PAIRS, 32'h3);
    wr(REG_PAIRS, 32'hd);
    w(1);
    chk("pairs", 32'h007, 32'(ch_en));
    // Permit contact on channel 0 with a two-second output delay
    wr(REG_CTRL, 32'h1);
    wr(REG_OUT_FUNC, 32'(FO_RUN_PERMIT));
    wr(REG_IN_DLY, 32'h2);
    @(posedge clk) blk <= 8'h00;
    w(8);
    chk("out_delay_early", 32'h0, 32'(rout[0]));
    w(30);
    chk("out_delay", 32'h1, 32'(rout[0]));
    @(posedge clk) rst_b <= 1'b0;
    w(2);
    chk("reset_heat", 32'h1, 32'(heat));
    chk("reset_out", 32'h0, 32'(rout));
    chk("reset_pairs", 32'hfff, 32'(ch_en));
    @(posedge clk) rst_b <= 1'b1;
    rd_chk(REG_IN_DLY, 32'(DLY_RESET));
    $display("test misc done");
    print_verdict();
  end
  // The sequence needs about 545 cycles
  initial begin
    repeat (4000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
endmodule
